// [hdl/rsic_top.sv]
// Clock status, interrupt enable, write protection and compensation registers
//
// Function
// - Status writes blocked until both keys correct
// - Alarm flag set on alarm while alarm enabled, held
// - Writing one clears alarm flag; zero ignored
// - Day increment flag shown while timer enabled
// - Hour increment flag shown while timer enabled
// - Minute increment flag shown while timer enabled
// - Second increment flag shown while timer enabled
// - Read-only running bit follows counter state
// - Busy during update and 15 us before
// - Interrupt enable writes blocked until unlocked
// - Alarm enable gates alarm match interrupt
// - Timer enable gates periodic interrupts
// - Period selector: second, minute, hour, day
// - Low compensation byte writes blocked until unlocked
// - Low and high bytes form compensation value
// - Compensation applied only with auto enable
// - Two's complement value; 7FFF is refused
// - Run control bit stops, resumes; status follows
`timescale 1ns/100ps
module rsic_top
    import rsic_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    input  wire logic        i_update_due,
    input  wire logic        i_incr_valid,
    input  wire rsic_incr_t  i_incr,
    input  wire logic        i_alarm_match,
    output logic             o_update,
    output logic             o_run,
    output logic             o_comp_enable,
    output logic      [15:0] o_comp_value,
    output logic             o_irq
);

    // ==========================================================
    // State
    // ==========================================================
    logic [31:0] key0_reg;
    logic [31:0] key0_next;
    logic [31:0] key1_reg;
    logic [31:0] key1_next;
    logic        unlock_reg;
    logic        unlock_next;
    logic        run_reg;
    logic        run_next;
    logic        auto_comp_enable_reg;
    logic        auto_comp_enable_next;
    logic [3:0]  int_en_reg;
    logic [3:0]  int_en_next;
    logic        alarm_flag_reg;
    logic        alarm_flag_next;
    rsic_incr_t  incr_flags_reg;
    rsic_incr_t  incr_flags_next;
    logic        tmr_pend_reg;
    logic        tmr_pend_next;
    logic [7:0]  comp_low_reg;
    logic [7:0]  comp_low_next;
    logic [7:0]  comp_high_reg;
    logic [7:0]  comp_high_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        irq_reg;
    logic        irq_next;
    logic        comp_en_reg;
    logic        comp_en_next;
    logic [15:0] comp_val_reg;
    logic [15:0] comp_val_next;

    logic        busy;
    logic        update_strobe;
    logic        alarm_en;
    logic        timer_en;
    logic [1:0]  period_sel;
    logic        period_hit;
    logic        wr_status;
    logic        wr_int_en;
    logic        wr_ctrl;
    logic        wr_comp_low;
    logic        wr_comp_high;
    logic        rd_status;
    rsic_incr_t  shown_flags;
    logic [31:0] status_word;

    // ==========================================================
    // Update lead timer
    // ==========================================================
    rsic_busy_lead u_busy_lead (
        .i_clk    (i_clk),
        .i_rst    (i_rst),
        .i_due    (i_update_due),
        .i_done   (i_incr_valid),
        .o_busy   (busy),
        .o_update (update_strobe)
    );

    // ==========================================================
    // Decode
    // ==========================================================
    assign alarm_en   = int_en_reg[RSIC_IE_ALARM_BIT];
    assign timer_en   = int_en_reg[RSIC_IE_TIMER_BIT];
    assign period_sel = int_en_reg[RSIC_IE_PERIOD_LSB +: 2];

    assign wr_status    = i_wr && unlock_reg && (i_addr == RSIC_OFF_STATUS);
    assign wr_int_en    = i_wr && unlock_reg && (i_addr == RSIC_OFF_INT_ENABLE);
    assign wr_ctrl      = i_wr && unlock_reg && (i_addr == RSIC_OFF_CONTROL);
    assign wr_comp_low  = i_wr && unlock_reg && (i_addr == RSIC_OFF_COMP_LOW);
    assign wr_comp_high = i_wr && unlock_reg && (i_addr == RSIC_OFF_COMP_HIGH);
    assign rd_status    = i_rd && (i_addr == RSIC_OFF_STATUS);

    always_comb begin
        case (rsic_period_t'(period_sel))
            RSIC_EVERY_SECOND: period_hit = i_incr.second;
            RSIC_EVERY_MINUTE: period_hit = i_incr.minute;
            RSIC_EVERY_HOUR:   period_hit = i_incr.hour;
            RSIC_EVERY_DAY:    period_hit = i_incr.day;
            default:           period_hit = 1'b0;
        endcase
    end

    // flags read zero with timer off
    assign shown_flags = timer_en ? incr_flags_reg : rsic_incr_t'(4'h0);

    always_comb begin
        status_word                    = RSIC_ST_RESERVED_ONES;
        status_word[RSIC_ST_ALARM_BIT] = alarm_flag_reg;
        status_word[RSIC_ST_DAY_BIT]   = shown_flags.day;
        status_word[RSIC_ST_HOUR_BIT]  = shown_flags.hour;
        status_word[RSIC_ST_MIN_BIT]   = shown_flags.minute;
        status_word[RSIC_ST_SEC_BIT]   = shown_flags.second;
        status_word[RSIC_ST_RUN_BIT]   = run_reg;
        status_word[RSIC_ST_BUSY_BIT]  = busy;
    end

    // ==========================================================
    // Write protection
    // ==========================================================
    always_comb begin
        key0_next = key0_reg;
        key1_next = key1_reg;
        if (i_wr && (i_addr == RSIC_OFF_KEY0)) begin
            key0_next = i_wdata;
        end
        if (i_wr && (i_addr == RSIC_OFF_KEY1)) begin
            key1_next = i_wdata;
        end
        unlock_next = (key0_next == RSIC_UNLOCK_KEY0) && (key1_next == RSIC_UNLOCK_KEY1);
    end

    // ==========================================================
    // Control, enables, compensation
    // ==========================================================
    always_comb begin
        run_next       = run_reg;
        auto_comp_enable_next  = auto_comp_enable_reg;
        int_en_next    = int_en_reg;
        comp_low_next  = comp_low_reg;
        comp_high_next = comp_high_reg;
        if (wr_ctrl) begin
            run_next      = i_wdata[RSIC_CTL_RUN_BIT];
            auto_comp_enable_next = i_wdata[RSIC_CTL_AUTO_COMP_ENABLE_BIT];
        end
        if (wr_int_en) begin
            int_en_next = i_wdata[3:0];
        end
        // refuse a write that would form the forbidden value
        if (wr_comp_low && ({comp_high_reg, i_wdata[7:0]} != RSIC_COMP_FORBIDDEN)) begin
            comp_low_next = i_wdata[7:0];
        end
        if (wr_comp_high && ({i_wdata[7:0], comp_low_reg} != RSIC_COMP_FORBIDDEN)) begin
            comp_high_next = i_wdata[7:0];
        end
        comp_val_next = {comp_high_next, comp_low_next};
        comp_en_next  = auto_comp_enable_next;
    end

    // ==========================================================
    // Events and interrupt
    // ==========================================================
    always_comb begin
        alarm_flag_next = alarm_flag_reg;
        incr_flags_next = incr_flags_reg;
        tmr_pend_next   = tmr_pend_reg;
        // write one clears; set below wins
        if (wr_status && i_wdata[RSIC_ST_ALARM_BIT]) begin
            alarm_flag_next = 1'b0;
        end
        if (i_alarm_match && alarm_en) begin
            alarm_flag_next = 1'b1;
        end
        // Reading status acknowledges the periodic event
        if (rd_status) begin
            tmr_pend_next = 1'b0;
        end
        if (i_incr_valid) begin
            incr_flags_next = i_incr;
            if (timer_en && period_hit) begin
                tmr_pend_next = 1'b1;
            end
        end
        irq_next = (alarm_flag_next && int_en_next[RSIC_IE_ALARM_BIT]) ||
                   (tmr_pend_next && int_en_next[RSIC_IE_TIMER_BIT]);
    end

    // ==========================================================
    // Read port
    // ==========================================================
    always_comb begin
        rdata_next = 32'h00000000;
        if (i_rd) begin
            case (i_addr)
                RSIC_OFF_CONTROL: begin
                    rdata_next[RSIC_CTL_RUN_BIT]      = run_reg;
                    rdata_next[RSIC_CTL_AUTO_COMP_ENABLE_BIT] = auto_comp_enable_reg;
                end
                RSIC_OFF_STATUS:     rdata_next = status_word;
                RSIC_OFF_INT_ENABLE: rdata_next[3:0] = int_en_reg;
                RSIC_OFF_COMP_LOW:   rdata_next[7:0] = comp_low_reg;
                RSIC_OFF_COMP_HIGH:  rdata_next[7:0] = comp_high_reg;
                RSIC_OFF_KEY0:       rdata_next = key0_reg;
                RSIC_OFF_KEY1:       rdata_next = key1_reg;
                default:             rdata_next = 32'h00000000;
            endcase
        end
    end

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            key0_reg       <= RSIC_KEY_RESET;
            key1_reg       <= RSIC_KEY_RESET;
            unlock_reg     <= 1'b0;
            run_reg        <= 1'b0;
            auto_comp_enable_reg   <= 1'b0;
            int_en_reg     <= RSIC_IE_RESET;
            alarm_flag_reg <= 1'b0;
            incr_flags_reg <= rsic_incr_t'(4'h0);
            tmr_pend_reg   <= 1'b0;
            comp_low_reg   <= RSIC_COMP_RESET;
            comp_high_reg  <= RSIC_COMP_RESET;
            rdata_reg      <= 32'h00000000;
            irq_reg        <= 1'b0;
            comp_en_reg    <= 1'b0;
            comp_val_reg   <= 16'h0000;
        end else begin
            key0_reg       <= key0_next;
            key1_reg       <= key1_next;
            unlock_reg     <= unlock_next;
            run_reg        <= run_next;
            auto_comp_enable_reg   <= auto_comp_enable_next;
            int_en_reg     <= int_en_next;
            alarm_flag_reg <= alarm_flag_next;
            incr_flags_reg <= incr_flags_next;
            tmr_pend_reg   <= tmr_pend_next;
            comp_low_reg   <= comp_low_next;
            comp_high_reg  <= comp_high_next;
            rdata_reg      <= rdata_next;
            irq_reg        <= irq_next;
            comp_en_reg    <= comp_en_next;
            comp_val_reg   <= comp_val_next;
        end
    end

    // counters take new time only between updates, software checks busy
    assign o_update      = update_strobe;
    assign o_run         = run_reg;
    assign o_comp_enable = comp_en_reg;
    assign o_comp_value  = comp_val_reg;
    assign o_irq         = irq_reg;
    assign o_rdata       = rdata_reg;

endmodule

// [pkg/rsic_pkg.sv]
// Package for the clock status and interrupt control block: map, fields, timing
package rsic_pkg;

    // ==========================================================
    // Register map (byte addresses)
    // ==========================================================
    localparam logic [7:0]  RSIC_OFF_CONTROL    = 8'h00;
    localparam logic [7:0]  RSIC_OFF_STATUS     = 8'h04;
    localparam logic [7:0]  RSIC_OFF_INT_ENABLE = 8'h08;
    localparam logic [7:0]  RSIC_OFF_COMP_LOW   = 8'h0C;
    localparam logic [7:0]  RSIC_OFF_COMP_HIGH  = 8'h10;
    localparam logic [7:0]  RSIC_OFF_KEY0       = 8'h14;
    localparam logic [7:0]  RSIC_OFF_KEY1       = 8'h18;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int RSIC_CTL_RUN_BIT      = 0;
    localparam int RSIC_CTL_AUTO_COMP_ENABLE_BIT = 2;
    localparam int RSIC_ST_BUSY_BIT      = 0;
    localparam int RSIC_ST_RUN_BIT       = 1;
    localparam int RSIC_ST_SEC_BIT       = 2;
    localparam int RSIC_ST_MIN_BIT       = 3;
    localparam int RSIC_ST_HOUR_BIT      = 4;
    localparam int RSIC_ST_DAY_BIT       = 5;
    localparam int RSIC_ST_ALARM_BIT     = 6;
    localparam int RSIC_IE_ALARM_BIT     = 3;
    localparam int RSIC_IE_TIMER_BIT     = 2;
    localparam int RSIC_IE_PERIOD_LSB    = 0;

    // ==========================================================
    // Values after reset and constants
    // ==========================================================
    localparam logic [31:0] RSIC_ST_RESERVED_ONES = 32'hFFFFFF80;
    localparam logic [3:0]  RSIC_IE_RESET         = 4'h0;
    localparam logic [7:0]  RSIC_COMP_RESET       = 8'h00;
    localparam logic [15:0] RSIC_COMP_FORBIDDEN   = 16'h7FFF;
    localparam logic [31:0] RSIC_KEY_RESET        = 32'h00000000;
    // Unlock keys: arbitrary values
    localparam logic [31:0] RSIC_UNLOCK_KEY0      = 32'h1234ABCD;
    localparam logic [31:0] RSIC_UNLOCK_KEY1      = 32'h5678EF01;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int          RSIC_CLK_PERIOD_NS = 100;
    localparam int          RSIC_BUSY_LEAD_US  = 15;
    // Least time: round up
    localparam int          RSIC_BUSY_LEAD_CYC =
        (RSIC_BUSY_LEAD_US * 1000 + RSIC_CLK_PERIOD_NS - 1) / RSIC_CLK_PERIOD_NS;
    localparam logic [7:0]  RSIC_LEAD_CNT_LAST = 8'(RSIC_BUSY_LEAD_CYC - 1);

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [1:0] {
        RSIC_EVERY_SECOND,
        RSIC_EVERY_MINUTE,
        RSIC_EVERY_HOUR,
        RSIC_EVERY_DAY
    } rsic_period_t;

    typedef struct packed {
        logic day;
        logic hour;
        logic minute;
        logic second;
    } rsic_incr_t;

endpackage

// [hdl/rsic_busy_lead.sv]
// Busy window: lead time before a time update, then the update strobe
`timescale 1ns/100ps
module rsic_busy_lead
    import rsic_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_due,
    input  wire logic i_done,
    output logic      o_busy,
    output logic      o_update
);

    typedef enum logic [1:0] {
        RSIC_LD_IDLE,
        RSIC_LD_LEAD,
        RSIC_LD_WAIT
    } rsic_lead_state_t;

    rsic_lead_state_t state_reg;
    rsic_lead_state_t state_next;
    logic [7:0]       cnt_reg;
    logic [7:0]       cnt_next;
    logic             busy_reg;
    logic             busy_next;
    logic             upd_reg;
    logic             upd_next;

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        upd_next   = 1'b0;
        case (state_reg)
            RSIC_LD_IDLE: begin
                if (i_due) begin
                    state_next = RSIC_LD_LEAD;
                    cnt_next   = 8'h00;
                end
            end
            RSIC_LD_LEAD: begin
                if (cnt_reg == RSIC_LEAD_CNT_LAST) begin
                    state_next = RSIC_LD_WAIT;
                    upd_next   = 1'b1;
                end else begin
                    cnt_next = cnt_reg + 8'h01;
                end
            end
            RSIC_LD_WAIT: begin
                // Busy holds until the counters report the update finished
                if (i_done) begin
                    state_next = RSIC_LD_IDLE;
                end
            end
            default: begin
                state_next = RSIC_LD_IDLE;
            end
        endcase
        busy_next = (state_next != RSIC_LD_IDLE);
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_reg <= RSIC_LD_IDLE;
            cnt_reg   <= 8'h00;
            busy_reg  <= 1'b0;
            upd_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            busy_reg  <= busy_next;
            upd_reg   <= upd_next;
        end
    end

    assign o_busy   = busy_reg;
    assign o_update = upd_reg;

endmodule

// [bench/rsic_top_sva.sv]
// Port checker for the clock status and interrupt control block
`timescale 1ns/100ps
module rsic_top_sva
    import rsic_pkg::*;
(
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic [7:0]  i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic        i_update_due,
    input wire logic        i_incr_valid,
    input wire rsic_incr_t  i_incr,
    input wire logic        i_alarm_match,
    input wire logic        o_update,
    input wire logic        o_run,
    input wire logic        o_comp_enable,
    input wire logic [15:0] o_comp_value,
    input wire logic        o_irq
);
    // ==========================================================
    // Shadow of keys and enables
    // ==========================================================
    logic [31:0] key0_reg;
    logic [31:0] key1_reg;
    logic [3:0]  ie_reg;
    logic [3:0]  incr_bits;
    logic        unl;
    assign incr_bits = i_incr;
    assign unl = (key0_reg == RSIC_UNLOCK_KEY0) && (key1_reg == RSIC_UNLOCK_KEY1);
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            key0_reg <= 32'h0;
            key1_reg <= 32'h0;
            ie_reg   <= 4'h0;
        end else if (i_wr) begin
            if (i_addr == RSIC_OFF_KEY0) key0_reg <= i_wdata;
            if (i_addr == RSIC_OFF_KEY1) key1_reg <= i_wdata;
            if (i_addr == RSIC_OFF_INT_ENABLE && unl) ie_reg <= i_wdata[3:0];
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence open_ctl_s;
        i_wr && unl && i_addr == RSIC_OFF_CONTROL;
    endsequence
    sequence shut_ctl_s;
        i_wr && !unl && i_addr == RSIC_OFF_CONTROL;
    endsequence
    sequence comp_hi_s;
        i_wr && unl && i_addr == RSIC_OFF_COMP_HIGH;
    endsequence
    // ==========================================================
    // Assertions
    // ==========================================================
    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data not zero outside read answer");
    update_lead_a: assert property (o_update |-> $past(i_update_due, 151))
        else $error("update strobe not at end of busy lead");
    update_pulse_a: assert property (o_update |=> !o_update)
        else $error("update strobe longer than one cycle");
    run_follow_a: assert property (open_ctl_s |=> o_run == $past(i_wdata[0])
        && o_comp_enable == $past(i_wdata[2]))
        else $error("control write not reflected");
    locked_ctl_a: assert property (shut_ctl_s |=> $stable(o_run) && $stable(o_comp_enable))
        else $error("control changed while locked");
    comp_high_a: assert property (comp_hi_s ##0 {i_wdata[7:0], o_comp_value[7:0]} != 16'h7FFF
        |=> o_comp_value[15:8] == $past(i_wdata[7:0]))
        else $error("high compensation byte not taken");
    comp_forbid_a: assert property (comp_hi_s ##0 {i_wdata[7:0], o_comp_value[7:0]} == 16'h7FFF
        |=> $stable(o_comp_value))
        else $error("forbidden compensation value taken");
    alarm_irq_a: assert property (i_alarm_match && ie_reg[3] |-> ##[1:2] o_irq)
        else $error("alarm did not raise interrupt");
    timer_irq_a: assert property (i_incr_valid && ie_reg[2] && incr_bits[ie_reg[1:0]]
        |-> ##[1:2] o_irq)
        else $error("periodic event did not raise interrupt");
    irq_quiet_a: assert property ((ie_reg[3:2] == 2'b00) [*3] |-> !o_irq)
        else $error("interrupt with all sources disabled");
endmodule

// [bench/tb.sv]
// Self-checking bench for the status and interrupt control block
`timescale 1ns/100ps
module tb
    import rsic_pkg::*;
;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic [7:0]  i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic        i_update_due = 1'b0;
    logic        i_incr_valid = 1'b0;
    rsic_incr_t  i_incr = 4'h0;
    logic        i_alarm_match = 1'b0;
    logic [31:0] o_rdata;
    logic        o_update;
    logic        o_run;
    logic        o_comp_enable;
    logic [15:0] o_comp_value;
    logic        o_irq;
    int          fails = 0;
    int          total_checks = 0;
    int          n;
    localparam logic [31:0] ST = RSIC_ST_RESERVED_ONES;

    always #50 i_clk = ~i_clk;

    rsic_top i_rsic_top (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_update_due(i_update_due),
        .i_incr_valid(i_incr_valid), .i_incr(i_incr), .i_alarm_match(i_alarm_match),
        .o_update(o_update), .o_run(o_run), .o_comp_enable(o_comp_enable),
        .o_comp_value(o_comp_value), .o_irq(o_irq));

    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd   <= 1'b0;
        #1 chk("rdata", o_rdata, exp);
    endtask
    // One-cycle pulse on an event input: 0 alarm, 1 increment, 2 update due
    task automatic ev(input int k, input logic [3:0] inc);
        @(posedge i_clk);
        if (k == 0) i_alarm_match <= 1'b1;
        if (k == 1) i_incr_valid <= 1'b1;
        if (k == 2) i_update_due <= 1'b1;
        i_incr <= inc;
        @(posedge i_clk);
        i_alarm_match <= 1'b0;
        i_incr_valid  <= 1'b0;
        i_update_due  <= 1'b0;
    endtask
    task automatic irq_is(input logic exp);
        repeat (3) @(posedge i_clk);
        #1 chk("irq", {31'h0, o_irq}, {31'h0, exp});
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // Tests
    // ==========================================================
    initial begin
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(RSIC_OFF_STATUS, ST);
        rd(RSIC_OFF_INT_ENABLE, 32'h0);
        rd(8'hFC, 32'h0);
        $display("test reset done");
        // Writes before the keys must all be dropped
        wr(RSIC_OFF_INT_ENABLE, 32'hF);
        wr(RSIC_OFF_CONTROL, 32'h5);
        wr(RSIC_OFF_COMP_LOW, 32'h55);
        rd(RSIC_OFF_INT_ENABLE, 32'h0);
        chk("run", {31'h0, o_run}, 32'h0);
        chk("comp", {16'h0, o_comp_value}, 32'h0);
        $display("test locked done");
        wr(RSIC_OFF_KEY0, RSIC_UNLOCK_KEY0);
        wr(RSIC_OFF_KEY1, RSIC_UNLOCK_KEY1);
        rd(RSIC_OFF_STATUS, ST);
        wr(RSIC_OFF_CONTROL, 32'h5);
        #1 chk("auto_comp_enable", {31'h0, o_comp_enable}, 32'h1);
        rd(RSIC_OFF_STATUS, ST | 32'h2);
        wr(RSIC_OFF_COMP_LOW, 32'hA5);
        wr(RSIC_OFF_COMP_HIGH, 32'h12);
        #1 chk("comp", {16'h0, o_comp_value}, 32'h12A5);
        wr(RSIC_OFF_COMP_LOW, 32'hFF);
        wr(RSIC_OFF_COMP_HIGH, 32'h7F);
        #1 chk("comp", {16'h0, o_comp_value}, 32'h12FF);
        wr(RSIC_OFF_CONTROL, 32'h0);
        rd(RSIC_OFF_STATUS, ST);
        $display("test unlocked done");
        wr(RSIC_OFF_INT_ENABLE, 32'h8);
        ev(0, 4'h0);
        irq_is(1'b1);
        rd(RSIC_OFF_STATUS, ST | 32'h40);
        wr(RSIC_OFF_STATUS, 32'h0);
        rd(RSIC_OFF_STATUS, ST | 32'h40);
        wr(RSIC_OFF_STATUS, 32'h40);
        rd(RSIC_OFF_STATUS, ST);
        irq_is(1'b0);
        wr(RSIC_OFF_INT_ENABLE, 32'h0);
        ev(0, 4'h0);
        irq_is(1'b0);
        rd(RSIC_OFF_STATUS, ST);
        $display("test alarm done");
        for (int p = 0; p < 4; p++) begin
            wr(RSIC_OFF_INT_ENABLE, 32'h4 | p);
            rd(RSIC_OFF_INT_ENABLE, 32'h4 | p);
            ev(1, 4'h1 << p);
            irq_is(1'b1);
            rd(RSIC_OFF_STATUS, ST | (32'h4 << p));
            irq_is(1'b0);
            ev(1, ~(4'h1 << p));
            irq_is(1'b0);
        end
        wr(RSIC_OFF_INT_ENABLE, 32'h0);
        ev(1, 4'hF);
        irq_is(1'b0);
        rd(RSIC_OFF_STATUS, ST);
        $display("test periodic done");
        ev(2, 4'h0);
        rd(RSIC_OFF_STATUS, ST | 32'h1);
        // The status read above already used two of the lead cycles
        n = 3;
        while (o_update !== 1'b1 && n < 400) begin
            @(posedge i_clk);
            #1 n++;
        end
        chk("lead", n, RSIC_BUSY_LEAD_CYC + 1);
        rd(RSIC_OFF_STATUS, ST | 32'h1);
        ev(1, 4'h0);
        rd(RSIC_OFF_STATUS, ST);
        $display("test busy done");
        wr(RSIC_OFF_INT_ENABLE, 32'h8);
        ev(0, 4'h0);
        // A wrong key must lock the registers again
        wr(RSIC_OFF_KEY1, 32'h0);
        wr(RSIC_OFF_STATUS, 32'h40);
        rd(RSIC_OFF_STATUS, ST | 32'h40);
        wr(RSIC_OFF_INT_ENABLE, 32'hF);
        rd(RSIC_OFF_INT_ENABLE, 32'h8);
        $display("test relock done");
        stop_test;
    end

    initial begin
        repeat (5000) @(posedge i_clk);
        fails++;
        stop_test;
    end
endmodule

bind rsic_top rsic_top_sva i_rsic_top_sva (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_update_due(i_update_due), .i_incr_valid(i_incr_valid), .i_incr(i_incr),
    .i_alarm_match(i_alarm_match), .o_update(o_update), .o_run(o_run),
    .o_comp_enable(o_comp_enable), .o_comp_value(o_comp_value), .o_irq(o_irq));
